//--- common/ustx_pkg.sv
// constants for the synchronous serial port block
package ustx_pkg;
  // register offsets (index; byte address is four times)
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_RX_CTRL = 8'h18;
  localparam logic [7:0] OFF_TX_BUF = 8'h19;
  localparam logic [7:0] OFF_RX_BUF = 8'h1A;
  localparam logic [7:0] OFF_IRQ_EN = 8'h8C;
  localparam logic [7:0] OFF_TX_CTRL = 8'h98;
  localparam logic [7:0] OFF_BAUD = 8'h99;
  // transmit status/control fields
  localparam int TXC_CLKSRC = 7;
  localparam int TXC_NINE = 6;
  localparam int TXC_ENABLE = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_HISPEED = 2;
  localparam int TXC_EMPTY = 1;
  localparam int TXC_NINTH = 0;
  // receive status/control fields
  localparam int RXC_PORTEN = 7;
  localparam int RXC_NINE = 6;
  localparam int RXC_SINGLE = 5;
  localparam int RXC_CONT = 4;
  localparam int RXC_FRAMING = 2;
  localparam int RXC_OVERRUN = 1;
  localparam int RXC_NINTH = 0;
  // flag and enable fields
  localparam int IRQ_RX = 5;
  localparam int IRQ_TX = 4;
  // reset values
  localparam logic [7:0] RST_TX_CTRL = 8'h02;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // sampling of the incoming data pin
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_RECV} ustx_state_t;
endpackage

//--- hw/ustx_baud_gen.sv
// baud generator: shift-clock edge enables from the divisor
`timescale 1ns/10ps
module ustx_baud_gen (
  input wire logic clock, // core clock
  input wire logic rstN, // synchronised reset, active low
  input wire logic run, // low holds generator in reset
  input wire logic [7:0] divisor, // reload value
  output logic riseEn, // one-cycle pulse: shift clock rises
  output logic fallEn // one-cycle pulse: shift clock falls
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic phase;
  logic next_phase;
  logic tick;

  // half-period counter, held at zero while not running
  always_comb
  begin
    tick = run && (count == 8'h00);
    next_count = count;
    next_phase = phase;
    if (!run)
    begin
      next_count = 8'h00;
      next_phase = 1'b0;
    end
    else if (tick)
    begin
      next_count = divisor;
      next_phase = ~phase;
    end
    else
    begin
      next_count = count - 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      count <= 8'h00;
      phase <= 1'b0;
    end
    else
    begin
      count <= next_count;
      phase <= next_phase;
    end
  end

  // phase low going high is a rising shift-clock edge
  assign riseEn = tick && !phase;
  assign fallEn = tick && phase;
endmodule

//--- hw/ustx_serial_port.sv
// synchronous master serial port with APB register access
// Functional notes
// - receive-ready flag set on completion; interrupt only when enabled
// - half duplex: transmit and receive never run together
// - sync select picks synchronous mode; port enable claims the pins
// - clock source select with sync select makes the device drive the clock line
// - shift register reloads from buffer only after last bit left
// - buffer transfer takes one cycle, then transmit-ready flag sets
// - transmit-ready flag read only; cleared only by buffer write
// - shift-register-empty status is read only and polled
// - first bit leaves on rising clock edge, stable at falling
// - baud generator held reset while all three enables clear
// - buffer write into empty shifter transfers at once
// - clearing transmit enable aborts, resets, frees data pin; clock freed unless receiving
// - receive enable aborts transmit, frees data pin, keeps clock
// - single receive clears itself, then transmit resumes if enabled
// - ninth bit sampled at the moment of buffer transfer
// - receive buffer is a two-entry queue
// - third word into full queue sets overrun and blocks transfers
// - framing flag and ninth bit queued with each word
`timescale 1ns/10ps
module ustx_serial_port (
  input wire logic clock, // core clock, 40 MHz
  input wire logic nrst, // asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic clockLineIn, // shift clock pin level
  output logic clockLineOut, // shift clock driven value
  output logic clockLineOe, // shift clock drive enable
  input wire logic dataLineIn, // data pin level
  output logic dataLineOut, // data driven value
  output logic dataLineOe, // data drive enable
  output logic receiveIrq // receive interrupt request
);
  logic rstSync1, rstN;
  logic [7:0] txCtrl, next_txCtrl;
  logic [7:0] rxCtrl, next_rxCtrl;
  logic [7:0] irqEn, next_irqEn;
  logic [7:0] baudDiv, next_baudDiv;
  logic [7:0] txBuf, next_txBuf;
  logic txBufFull, next_txBufFull;
  logic txReady, next_txReady;
  logic [8:0] shiftReg, next_shiftReg;
  logic [3:0] bitsLeft, next_bitsLeft;
  logic clkLevel, next_clkLevel;
  logic dataOut, next_dataOut;
  logic [8:0] rxShift, next_rxShift;
  logic [3:0] rxCount, next_rxCount;
  logic [9:0] rxQueue [2];
  logic [9:0] next_rxQueue [2];
  logic [1:0] rxLevel, next_rxLevel;
  logic [31:0] next_prdata;
  ustx_pkg::ustx_state_t state, next_state;
  logic [ustx_pkg::SYNC_STAGES-1:0] dataSync;
  logic wrEn, rdEn, riseEn, fallEn, baudRun;
  logic transmit_enable, rxEn, master, portOn, nineTx, nineRx;
  logic [7:0] addrIdx;
  logic addrOk;
  logic clkUnused;

  // reset release through two flip-flops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync1 <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstN <= rstSync1;
    end
  end

  // data pin sampled through two flip-flops
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      dataSync <= '0;
    else
      dataSync <= {dataSync[0], dataLineIn};
  end

  // pin level read back is not used by master logic
  assign clkUnused = clockLineIn;

  // APB decode: zero-wait access phase
  assign addrIdx = paddr[9:2];
  assign addrOk = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
    ((addrIdx == ustx_pkg::OFF_IRQ_FLAGS) ||
     (addrIdx == ustx_pkg::OFF_RX_CTRL) ||
     (addrIdx == ustx_pkg::OFF_TX_BUF) ||
     (addrIdx == ustx_pkg::OFF_RX_BUF) ||
     (addrIdx == ustx_pkg::OFF_IRQ_EN) ||
     (addrIdx == ustx_pkg::OFF_TX_CTRL) ||
     (addrIdx == ustx_pkg::OFF_BAUD));
  assign wrEn = psel && penable && pwrite && addrOk;
  assign rdEn = psel && penable && !pwrite && addrOk;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addrOk;

  // decoded control bits
  assign transmit_enable = txCtrl[ustx_pkg::TXC_ENABLE];
  assign rxEn = rxCtrl[ustx_pkg::RXC_CONT] || rxCtrl[ustx_pkg::RXC_SINGLE];
  assign master = txCtrl[ustx_pkg::TXC_CLKSRC] && txCtrl[ustx_pkg::TXC_SYNC];
  assign portOn = rxCtrl[ustx_pkg::RXC_PORTEN];
  assign nineTx = txCtrl[ustx_pkg::TXC_NINE];
  assign nineRx = rxCtrl[ustx_pkg::RXC_NINE];
  assign baudRun = transmit_enable || rxEn;

  ustx_baud_gen baudGen (
    .clock(clock),
    .rstN(rstN),
    .run(baudRun),
    .divisor(baudDiv),
    .riseEn(riseEn),
    .fallEn(fallEn)
  );

  // registers, transmit path, receive path
  always_comb
  begin
    next_txCtrl = txCtrl;
    next_rxCtrl = rxCtrl;
    next_irqEn = irqEn;
    next_baudDiv = baudDiv;
    next_txBuf = txBuf;
    next_txBufFull = txBufFull;
    next_txReady = txReady;
    next_shiftReg = shiftReg;
    next_bitsLeft = bitsLeft;
    next_clkLevel = clkLevel;
    next_dataOut = dataOut;
    next_rxShift = rxShift;
    next_rxCount = rxCount;
    next_rxQueue = rxQueue;
    next_rxLevel = rxLevel;
    next_state = state;
    next_prdata = prdata;
    // register writes
    if (wrEn)
    begin
      if (addrIdx == ustx_pkg::OFF_TX_CTRL)
      begin
        next_txCtrl = pwdata[7:0] & 8'hF5;
        next_txCtrl[ustx_pkg::TXC_EMPTY] = txCtrl[ustx_pkg::TXC_EMPTY];
      end
      else if (addrIdx == ustx_pkg::OFF_RX_CTRL)
      begin
        next_rxCtrl[7:4] = pwdata[7:4];
        if (!pwdata[ustx_pkg::RXC_CONT])
          next_rxCtrl[ustx_pkg::RXC_OVERRUN] = 1'b0;
      end
      else if (addrIdx == ustx_pkg::OFF_IRQ_EN)
        next_irqEn = pwdata[7:0];
      else if (addrIdx == ustx_pkg::OFF_BAUD)
        next_baudDiv = pwdata[7:0];
      else if (addrIdx == ustx_pkg::OFF_TX_BUF)
      begin
        next_txBuf = pwdata[7:0];
        next_txBufFull = 1'b1;
        next_txReady = 1'b0;
      end
    end
    // enabling transmit marks buffer ready
    if (next_txCtrl[ustx_pkg::TXC_ENABLE] && !transmit_enable && !next_txBufFull)
      next_txReady = 1'b1;
    // receive buffer read pops the queue and loads status bits
    if (rdEn && addrIdx == ustx_pkg::OFF_RX_BUF && rxLevel != 2'd0)
    begin
      next_rxQueue[0] = rxQueue[1];
      next_rxLevel = rxLevel - 2'd1;
    end
    // transmit and receive state machine
    case (state)
      ustx_pkg::ST_IDLE:
      begin
        next_clkLevel = 1'b0;
        if (rxEn && master && portOn)
        begin
          next_state = ustx_pkg::ST_RECV;
          next_rxCount = 4'd0;
        end
        else if (transmit_enable && txBufFull)
        begin
          next_shiftReg = {txCtrl[ustx_pkg::TXC_NINTH], txBuf};
          next_bitsLeft = nineTx ? 4'd9 : 4'd8;
          next_txBufFull = 1'b0;
          next_txReady = 1'b1;
          next_state = ustx_pkg::ST_SHIFT;
        end
      end
      ustx_pkg::ST_SHIFT:
      begin
        if (rxEn)
          next_state = ustx_pkg::ST_IDLE;
        else if (riseEn)
        begin
          next_clkLevel = 1'b1;
          next_dataOut = shiftReg[0];
          next_shiftReg = {1'b0, shiftReg[8:1]};
          next_bitsLeft = bitsLeft - 4'd1;
        end
        else if (fallEn)
        begin
          next_clkLevel = 1'b0;
          if (bitsLeft == 4'd0)
          begin
            if (txBufFull)
            begin
              next_shiftReg = {txCtrl[ustx_pkg::TXC_NINTH], txBuf};
              next_bitsLeft = nineTx ? 4'd9 : 4'd8;
              next_txBufFull = 1'b0;
              next_txReady = 1'b1;
            end
            else
              next_state = ustx_pkg::ST_IDLE;
          end
        end
      end
      default:
      begin
        if (!rxEn)
          next_state = ustx_pkg::ST_IDLE;
        else if (riseEn)
          next_clkLevel = 1'b1;
        else if (fallEn && clkLevel) // only after a driven rise
        begin
          // data sampled on the falling clock edge
          next_clkLevel = 1'b0;
          next_rxShift = {dataSync[1], rxShift[8:1]};
          next_rxCount = rxCount + 4'd1;
          if (rxCount + 4'd1 == (nineRx ? 4'd9 : 4'd8))
          begin
            next_rxCount = 4'd0;
            if (!rxCtrl[ustx_pkg::RXC_CONT])
            begin
              next_rxCtrl[ustx_pkg::RXC_SINGLE] = 1'b0;
              next_state = ustx_pkg::ST_IDLE;
            end
            if (rxCtrl[ustx_pkg::RXC_OVERRUN])
              ; // transfers blocked until cleared
            else if (next_rxLevel == 2'd2)
              next_rxCtrl[ustx_pkg::RXC_OVERRUN] = 1'b1;
            else
            begin
              // framing slot stays clear in synchronous mode
              next_rxQueue[next_rxLevel[0]] = nineRx ?
                {1'b0, dataSync[1], rxShift[8:1]} :
                {2'b00, dataSync[1], rxShift[8:2]};
              next_rxLevel = next_rxLevel + 2'd1;
            end
          end
        end
      end
    endcase
    // clearing transmit enable resets the transmitter
    if (!transmit_enable)
    begin
      next_shiftReg = 9'h000;
      next_bitsLeft = 4'd0;
      next_dataOut = 1'b0;
      if (state == ustx_pkg::ST_SHIFT)
        next_state = ustx_pkg::ST_IDLE;
    end
    // head entry status bits mirror into receive control
    next_rxCtrl[ustx_pkg::RXC_NINTH] = next_rxQueue[0][8];
    next_rxCtrl[ustx_pkg::RXC_FRAMING] = next_rxQueue[0][9];
    next_txCtrl[ustx_pkg::TXC_EMPTY] = (next_state != ustx_pkg::ST_SHIFT);
    // read data is registered in the setup phase
    if (psel && !penable)
    begin
      next_prdata = 32'h0000_0000;
      if (addrIdx == ustx_pkg::OFF_TX_CTRL)
        next_prdata[7:0] = txCtrl;
      else if (addrIdx == ustx_pkg::OFF_RX_CTRL)
        next_prdata[7:0] = rxCtrl;
      else if (addrIdx == ustx_pkg::OFF_IRQ_EN)
        next_prdata[7:0] = irqEn;
      else if (addrIdx == ustx_pkg::OFF_BAUD)
        next_prdata[7:0] = baudDiv;
      else if (addrIdx == ustx_pkg::OFF_TX_BUF)
        next_prdata[7:0] = txBuf;
      else if (addrIdx == ustx_pkg::OFF_RX_BUF)
        next_prdata[7:0] = rxQueue[0][7:0];
      else if (addrIdx == ustx_pkg::OFF_IRQ_FLAGS)
      begin
        next_prdata[ustx_pkg::IRQ_RX] = (rxLevel != 2'd0);
        next_prdata[ustx_pkg::IRQ_TX] = txReady;
      end
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      txCtrl <= ustx_pkg::RST_TX_CTRL;
      rxCtrl <= ustx_pkg::RST_ZERO;
      irqEn <= ustx_pkg::RST_ZERO;
      baudDiv <= ustx_pkg::RST_ZERO;
      txBuf <= ustx_pkg::RST_ZERO;
      txBufFull <= 1'b0;
      txReady <= 1'b0;
      shiftReg <= 9'h000;
      bitsLeft <= 4'h0;
      clkLevel <= 1'b0;
      dataOut <= 1'b0;
      rxShift <= 9'h000;
      rxCount <= 4'h0;
      rxQueue[0] <= 10'h000;
      rxQueue[1] <= 10'h000;
      rxLevel <= 2'd0;
      state <= ustx_pkg::ST_IDLE;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      txCtrl <= next_txCtrl;
      rxCtrl <= next_rxCtrl;
      irqEn <= next_irqEn;
      baudDiv <= next_baudDiv;
      txBuf <= next_txBuf;
      txBufFull <= next_txBufFull;
      txReady <= next_txReady;
      shiftReg <= next_shiftReg;
      bitsLeft <= next_bitsLeft;
      clkLevel <= next_clkLevel;
      dataOut <= next_dataOut;
      rxShift <= next_rxShift;
      rxCount <= next_rxCount;
      rxQueue <= next_rxQueue;
      rxLevel <= next_rxLevel;
      state <= next_state;
      prdata <= next_prdata;
    end
  end

  // pin drive: clock by master, data while transmit enabled and not receiving
  assign clockLineOe = portOn && master && (transmit_enable || rxEn);
  assign clockLineOut = clkLevel;
  assign dataLineOe = portOn && transmit_enable && !rxEn &&
    (state != ustx_pkg::ST_RECV);
  assign dataLineOut = dataOut;
  assign receiveIrq = (rxLevel != 2'd0) && irqEn[ustx_pkg::IRQ_RX];
endmodule

//--- tb/ustx_serial_port_props.sv
// assertion checker watching the serial port pins
`timescale 1ns/10ps
module ustx_serial_port_props (
  input wire logic clock, // core clock
  input wire logic nrst, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic clockLineOut, // shift clock value
  input wire logic clockLineOe, // shift clock enable
  input wire logic dataLineOut, // data value
  input wire logic dataLineOe, // data enable
  input wire logic receiveIrq // receive request
);
  logic [7:0] txC;
  logic [7:0] rxC;
  logic [7:0] irqE;
  logic wr;
  logic quiet;
  assign wr = psel && penable && pwrite;
  assign quiet = !(txC[5] || rxC[4] || rxC[5]);
  // shadow copies of written control registers
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      txC <= 8'h00;
      rxC <= 8'h00;
      irqE <= 8'h00;
    end
    else if (wr)
    begin
      if (paddr == 12'h260)
        txC <= pwdata[7:0];
      if (paddr == 12'h060)
        rxC <= pwdata[7:0];
      if (paddr == 12'h230)
        irqE <= pwdata[7:0];
    end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  chk_enable_abort: assert property (
    wr && paddr == 12'h260 && !pwdata[5] && txC[5] && !rxC[4] && !rxC[5]
    |-> ##[1:3] !dataLineOe && !clockLineOe)
    else $error("pins not released after transmit disable");
  chk_idle_clock: assert property (quiet [*3] |-> !clockLineOut)
    else $error("shift clock moves while generator held");
  chk_data_rise: assert property (
    dataLineOe && $past(dataLineOe) && $changed(dataLineOut)
    |-> $rose(clockLineOut))
    else $error("data changed away from clock rise");
  chk_data_fall: assert property (
    $fell(clockLineOut) && dataLineOe |-> $stable(dataLineOut))
    else $error("data moved at clock fall");
  chk_clock_master: assert property (
    clockLineOe |-> txC[7] && rxC[7])
    else $error("clock driven outside master mode");
  chk_data_port: assert property (
    dataLineOe |-> rxC[7] && txC[4] && txC[5])
    else $error("data driven without port enabled");
  chk_half_duplex: assert property (rxC[4] [*3] |-> !dataLineOe)
    else $error("data driven while receiving");
  chk_rx_clock: assert property (
    (rxC[4] && txC[7] && rxC[7]) [*3] |-> clockLineOe)
    else $error("clock released during reception");
  chk_irq_gate: assert property (receiveIrq |-> irqE[5])
    else $error("receive request while disabled");
  cover property (wr && paddr == 12'h064);
  cover property (rxC[4] && clockLineOe);
  cover property ($rose(receiveIrq));
endmodule
bind ustx_serial_port ustx_serial_port_props ustx_serial_port_props_inst (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .clockLineOut(clockLineOut), .clockLineOe(clockLineOe),
  .dataLineOut(dataLineOut), .dataLineOe(dataLineOe),
  .receiveIrq(receiveIrq));

//--- tb/ustx_peer.sv
// serial peer: captures shifted bits, toggles data when free
`timescale 1ns/10ps
module ustx_peer (
  input wire logic clock, // core clock
  input wire logic clr, // clears the capture
  input wire logic lineClk, // shift clock level
  input wire logic lineData, // data pin level
  input wire logic dutDrives, // device drives data
  output logic peerData, // level the peer drives
  output logic [7:0] bitCount, // bits captured
  output logic [31:0] shifted // captured bits, newest on top
);
  logic prevClk;
  // sample at each falling shift clock edge while the device drives data
  always_ff @(posedge clock)
  begin
    prevClk <= lineClk;
    peerData <= (dutDrives || clr) ? 1'h0 : !peerData;
    if (clr)
    begin
      bitCount <= 8'h00;
      shifted <= 32'h0;
    end
    else if (prevClk && !lineClk && dutDrives)
    begin
      bitCount <= bitCount + 8'h01;
      shifted <= {lineData, shifted[31:1]};
    end
  end
endmodule

//--- tb/testbench.sv
// self-checking bench for the serial port
`timescale 1ns/10ps
module testbench;
  logic clock, nrst, psel, penable, pwrite, clr, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, shifted;
  logic pready, pslverr, clockLineOut, clockLineOe, dataLineOut;
  logic dataLineOe, receiveIrq, peerData, clockLineIn, dataLineIn;
  logic [7:0] bitCount;
  int miscompares, n_tests;
  assign clockLineIn = clockLineOe ? clockLineOut : !clockLineOut;
  assign dataLineIn = dataLineOe ? dataLineOut : peerData;
  ustx_serial_port ustx_serial_port_inst (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clockLineIn(clockLineIn), .clockLineOut(clockLineOut),
    .clockLineOe(clockLineOe), .dataLineIn(dataLineIn),
    .dataLineOut(dataLineOut), .dataLineOe(dataLineOe),
    .receiveIrq(receiveIrq));
  ustx_peer ustx_peer_inst (.clock(clock), .clr(clr),
    .lineClk(clockLineOut), .lineData(dataLineIn), .dutDrives(dataLineOe),
    .peerData(peerData), .bitCount(bitCount), .shifted(shifted));
  // clock generation
  initial
  begin
    clock = 1'h0;
    forever #12.5 clock = !clock;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1 && k < 16)
    begin
      @(posedge clock);
      k++;
    end
    rdata = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 16)
    begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic rdChk(input logic [7:0] i, input logic [31:0] e);
    apb(1'h0, i, 8'h00);
    check(rdata, e);
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: return clockLineOut;
      1: return bitCount == 8'h10;
      2: return bitCount == 8'h09;
      3: return receiveIrq;
      4: return rdata[1];
      default: return dataLineOe;
    endcase
  endfunction
  task automatic waitFor(input int s, input int lim);
    int k;
    k = 0;
    while (cond(s) !== 1'h1 && k < lim)
    begin
      if (s == 4)
        apb(1'h0, ustx_pkg::OFF_TX_CTRL, 8'h00);
      else
        @(posedge clock);
      k++;
    end
    if (k >= lim)
    begin
      miscompares++;
      summarize();
    end
  endtask
  // main sequence
  initial
  begin
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    clr = 1'h1;
    repeat (8) @(posedge clock);
    nrst <= 1'h1;
    clr <= 1'h0;
    repeat (3) @(posedge clock);
    rdChk(ustx_pkg::OFF_TX_CTRL, 32'h02);
    rdChk(ustx_pkg::OFF_IRQ_FLAGS, 32'h00);
    rdChk(ustx_pkg::OFF_BAUD, 32'h00);
    rdChk(ustx_pkg::OFF_IRQ_EN, 32'h00);
    apb(1'h1, ustx_pkg::OFF_TX_CTRL, 8'h00);
    rdChk(ustx_pkg::OFF_TX_CTRL, 32'h02);
    rdChk(8'h01, 32'h00);
    check(32'(lastErr), 32'h1);
    apb(1'h1, ustx_pkg::OFF_BAUD, 8'h03);
    // asynchronous setup: no master clock may appear
    apb(1'h1, ustx_pkg::OFF_RX_CTRL, 8'h90);
    @(posedge clock);
    check(32'(clockLineOe), 32'h0);
    apb(1'h1, ustx_pkg::OFF_RX_CTRL, 8'h80);
    apb(1'h1, ustx_pkg::OFF_TX_CTRL, 8'h90);
    apb(1'h1, ustx_pkg::OFF_RX_CTRL, 8'h80);
    apb(1'h1, ustx_pkg::OFF_IRQ_EN, 8'h10);
    check(32'(clockLineOut), 32'h0);
    apb(1'h1, ustx_pkg::OFF_TX_CTRL, 8'hB0);
    rdChk(ustx_pkg::OFF_IRQ_FLAGS, 32'h10);
    // two words back to back; clock starts with the first
    apb(1'h1, ustx_pkg::OFF_TX_BUF, 8'hA5);
    waitFor(0, 20);
    rdChk(ustx_pkg::OFF_IRQ_FLAGS, 32'h10);
    rdChk(ustx_pkg::OFF_TX_CTRL, 32'hB0);
    apb(1'h1, ustx_pkg::OFF_TX_BUF, 8'h3C);
    rdChk(ustx_pkg::OFF_IRQ_FLAGS, 32'h00);
    apb(1'h1, ustx_pkg::OFF_IRQ_FLAGS, 8'hFF);
    rdChk(ustx_pkg::OFF_IRQ_FLAGS, 32'h00);
    waitFor(1, 400);
    check({16'h0, shifted[31:16]}, 32'h3CA5);
    rdata = 32'h0;
    waitFor(4, 60);
    check(rdata, 32'hB2);
    rdChk(ustx_pkg::OFF_IRQ_FLAGS, 32'h10);
    // nine bits, ninth changed after the load
    clr <= 1'h1;
    apb(1'h1, ustx_pkg::OFF_TX_CTRL, 8'hF1);
    clr <= 1'h0;
    apb(1'h1, ustx_pkg::OFF_TX_BUF, 8'h5A);
    apb(1'h1, ustx_pkg::OFF_TX_CTRL, 8'hF0);
    waitFor(2, 300);
    check({23'h0, shifted[31:23]}, 32'h15A);
    rdata = 32'h0;
    waitFor(4, 60);
    // receive enable aborts, then transmit disable resets
    apb(1'h1, ustx_pkg::OFF_TX_CTRL, 8'hB0);
    apb(1'h1, ustx_pkg::OFF_TX_BUF, 8'hFF);
    apb(1'h1, ustx_pkg::OFF_RX_CTRL, 8'h90);
    @(posedge clock);
    check(32'(dataLineOe), 32'h0);
    check(32'(clockLineOe), 32'h1);
    apb(1'h1, ustx_pkg::OFF_RX_CTRL, 8'h80);
    apb(1'h1, ustx_pkg::OFF_TX_CTRL, 8'h90);
    @(posedge clock);
    check({30'h0, dataLineOe, clockLineOe}, 32'h0);
    rdChk(ustx_pkg::OFF_TX_CTRL, 32'h92);
    // single word reception, then transmit resumes
    apb(1'h1, ustx_pkg::OFF_IRQ_EN, 8'h20);
    apb(1'h1, ustx_pkg::OFF_TX_CTRL, 8'hB0);
    apb(1'h1, ustx_pkg::OFF_RX_CTRL, 8'hA0);
    waitFor(3, 400);
    rdChk(ustx_pkg::OFF_IRQ_FLAGS, 32'h30);
    apb(1'h0, ustx_pkg::OFF_RX_CTRL, 8'h00);
    check(rdata & 32'hF0, 32'h80);
    waitFor(5, 40);
    apb(1'h0, ustx_pkg::OFF_RX_BUF, 8'h00);
    @(posedge clock);
    check(32'(receiveIrq), 32'h0);
    summarize();
  end
endmodule
